// [design/sdi_input_if.sv]
`timescale 1ns/1ps

module sdi_input_if (
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        sclk_i,
    input  wire logic        sdata_i,
    input  wire logic        cs_n_i,
    input  wire logic        dac_update_strobe_n_i,
    output logic [15:0]      dac_code_o,
    output logic [15:0]      bipolar_signed_o,
    output logic             dac_updated_o,
    output logic             frame_active_o,
    output logic [4:0]       bit_count_o
);
    // -------------------------------------------------------------------------
    // Pin synchronisation.
    // -------------------------------------------------------------------------
    // The serial clock must run well below a quarter of the reference clock
    // for edges to be seen; at 20 MHz this limits the link to about 5 MHz.
    // Data passes the same two stages as the serial clock, so the bit seen at a
    // detected rise is the one the host held steady around that pin edge.
    logic sclk_s;
    logic sdata_s;
    logic cs_n_s;
    logic upd_n_s;

    sdi_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (sclk_i),
        .sync_o    (sclk_s)
    );
    sdi_sync #(.RESET_VAL(1'b0)) u_sync_sdata (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (sdata_i),
        .sync_o    (sdata_s)
    );
    // Chip select and the load strobe reset high, their idle level, so that a
    // reset never looks like the start of a frame.
    sdi_sync #(.RESET_VAL(1'b1)) u_sync_cs (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (cs_n_i),
        .sync_o    (cs_n_s)
    );
    sdi_sync #(.RESET_VAL(1'b1)) u_sync_upd (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (dac_update_strobe_n_i),
        .sync_o    (upd_n_s)
    );

    // -------------------------------------------------------------------------
    // Edge detection.
    // -------------------------------------------------------------------------
    logic sclk_d;
    logic cs_n_d;
    logic upd_n_d;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    logic upd_fall;

    // The delayed copies reset to each pin's idle level so that no false edge
    // follows reset. A load strobe tied low still shows one fall after reset,
    // which is harmless because nothing is pending then.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_d  <= 1'b0;
            cs_n_d  <= 1'b1;
            upd_n_d <= 1'b1;
        end else begin
            sclk_d  <= sclk_s;
            cs_n_d  <= cs_n_s;
            upd_n_d <= upd_n_s;
        end
    end

    always_comb begin
        sclk_rise = sclk_s & ~sclk_d;
        cs_fall   = cs_n_d & ~cs_n_s;
        cs_rise   = ~cs_n_d & cs_n_s;
        upd_fall  = upd_n_d & ~upd_n_s;
    end

    // -------------------------------------------------------------------------
    // Shift register. No reset: its power-up contents are undefined.
    // -------------------------------------------------------------------------
    // A mid-run reset leaves the bits in place as well, so a short frame after
    // it mixes old and new bits exactly as after any other frame. The host is
    // expected to send a full word first.
    logic [15:0] shift_reg;
    logic [15:0] next_shift_reg;

    always_comb begin
        next_shift_reg = shift_reg;
        if (!cs_n_s && sclk_rise) begin
            next_shift_reg = {shift_reg[14:0], sdata_s};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        shift_reg <= next_shift_reg;
    end

    // -------------------------------------------------------------------------
    // Frame control and DAC register.
    // -------------------------------------------------------------------------
    sdi_pkg::sdi_state_t state;
    sdi_pkg::sdi_state_t next_state;
    logic [4:0]  next_bit_count;
    logic [15:0] next_dac_code;
    logic        next_dac_updated;
    logic        pending;
    logic        next_pending;

    // An update that finds the load strobe high waits in pending until the
    // strobe falls. A new frame drops a waiting update, so a late strobe can
    // never load a word that is only partly shifted. A strobe fall inside a
    // frame is ignored; only a select rise closes one.
    // An update at select rise ignores the bit count, so a short frame loads
    // old and new bits together. The count saturates so that a long frame
    // cannot wrap it back to a small value.
    always_comb begin
        next_state       = state;
        next_bit_count   = bit_count_o;
        next_dac_code    = dac_code_o;
        next_dac_updated = 1'b0;
        next_pending     = pending;
        case (state)
            sdi_pkg::SDI_IDLE: begin
                if (cs_fall) begin
                    next_state     = sdi_pkg::SDI_FRAME;
                    next_bit_count = sdi_pkg::CNT_RESET;
                    next_pending   = 1'b0;
                end else if (pending && upd_fall) begin
                    next_dac_code    = shift_reg;
                    next_dac_updated = 1'b1;
                    next_pending     = 1'b0;
                end
            end
            sdi_pkg::SDI_FRAME: begin
                if (sclk_rise && bit_count_o != sdi_pkg::FULL_WORD_CNT) begin
                    next_bit_count = bit_count_o + 5'h01;
                end
                if (cs_rise) begin
                    next_state = sdi_pkg::SDI_IDLE;
                    if (!upd_n_s) begin
                        next_dac_code    = shift_reg;
                        next_dac_updated = 1'b1;
                    end else begin
                        next_pending = 1'b1;
                    end
                end
            end
            default: begin
                next_state = sdi_pkg::SDI_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state         <= sdi_pkg::SDI_IDLE;
            bit_count_o   <= sdi_pkg::CNT_RESET;
            dac_code_o    <= sdi_pkg::DAC_RESET_CODE;
            dac_updated_o <= 1'b0;
            pending       <= 1'b0;
        end else begin
            state         <= next_state;
            bit_count_o   <= next_bit_count;
            dac_code_o    <= next_dac_code;
            dac_updated_o <= next_dac_updated;
            pending       <= next_pending;
        end
    end

    // -------------------------------------------------------------------------
    // Registered status and bipolar view.
    // -------------------------------------------------------------------------
    // Flipping the MSB turns the offset-binary code into two's complement, so a
    // signed consumer needs no adder. Both views come from the same next value,
    // which keeps them in step on every update.
    logic        next_frame_active;
    logic [15:0] next_bipolar;

    always_comb begin
        next_frame_active = (next_state == sdi_pkg::SDI_FRAME);
        next_bipolar      = next_dac_code ^ sdi_pkg::BIPOLAR_ZERO;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_active_o   <= 1'b0;
            bipolar_signed_o <= sdi_pkg::DAC_RESET_CODE ^ sdi_pkg::BIPOLAR_ZERO;
        end else begin
            frame_active_o   <= next_frame_active;
            bipolar_signed_o <= next_bipolar;
        end
    end
endmodule

// [design/sdi_pkg.sv]
package sdi_pkg;
    localparam int          WORD_BITS      = 16;
    localparam int          CNT_BITS       = 5;
    localparam logic [15:0] DAC_RESET_CODE = 16'h0000;
    localparam logic [15:0] BIPOLAR_ZERO   = 16'h8000;
    localparam logic [4:0]  FULL_WORD_CNT  = 5'h10;
    localparam logic [4:0]  CNT_RESET      = 5'h00;
    localparam logic [1:0]  SYNC_RESET     = 2'h3;
    localparam logic [1:0]  SYNC_RESET_CLK = 2'h0;
    localparam int          MAX_SCLK_MHZ   = 25;
    localparam int          REF_CLK_MHZ    = 20;
    typedef enum logic [0:0] {SDI_IDLE, SDI_FRAME} sdi_state_t;
endpackage

// [design/sdi_sync.sv]
`timescale 1ns/1ps

// -----------------------------------------------------------------------------
// Two flip-flop synchroniser for one pin.
// -----------------------------------------------------------------------------
module sdi_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic pin_i,
    output logic      sync_o
);
    logic stage1;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stage1 <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            stage1 <= pin_i;
            sync_o <= stage1;
        end
    end
endmodule

// [verification/sdi_input_if_props.sv]
`timescale 1ns/1ps

module sdi_input_if_props (
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        sclk_i,
    input  wire logic        sdata_i,
    input  wire logic        cs_n_i,
    input  wire logic        dac_update_strobe_n_i,
    input  wire logic [15:0] dac_code_o,
    input  wire logic [15:0] bipolar_signed_o,
    input  wire logic        dac_updated_o,
    input  wire logic        frame_active_o,
    input  wire logic [4:0]  bit_count_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence sel_rise_s;
        $rose(cs_n_i) && !dac_update_strobe_n_i;
    endsequence
    bip_view_a: assert property (bipolar_signed_o == {~dac_code_o[15], dac_code_o[14:0]})
        else $error("Bipolar view differs from code");
    code_hold_a: assert property (!dac_updated_o |-> $stable(dac_code_o))
        else $error("Code changed without update pulse");
    upd_pulse_a: assert property (dac_updated_o |=> !dac_updated_o)
        else $error("Update pulse longer than one cycle");
    cnt_sat_a: assert property (bit_count_o <= sdi_pkg::FULL_WORD_CNT)
        else $error("Bit count above word size");
    idle_off_a: assert property (cs_n_i[*5] |-> !frame_active_o)
        else $error("Frame open while select high");
    frame_open_a: assert property ($fell(cs_n_i) |-> ##[2:5] frame_active_o)
        else $error("Frame did not open");
    sel_update_a: assert property (sel_rise_s |-> ##[2:6] dac_updated_o)
        else $error("Select rise gave no update");
    busy_no_upd_a: assert property ((!cs_n_i)[*8] |-> !dac_updated_o)
        else $error("Update during frame");
endmodule

bind sdi_input_if sdi_input_if_props i_props (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .sclk_i(sclk_i), .sdata_i(sdata_i), .cs_n_i(cs_n_i),
    .dac_update_strobe_n_i(dac_update_strobe_n_i), .dac_code_o(dac_code_o),
    .bipolar_signed_o(bipolar_signed_o), .dac_updated_o(dac_updated_o),
    .frame_active_o(frame_active_o), .bit_count_o(bit_count_o));

// [verification/sdi_host.sv]
`timescale 1ns/1ps

module sdi_host (
    input  wire logic clk_i,
    output logic      sclk_o,
    output logic      sdata_o,
    output logic      cs_n_o,
    output logic      strobe_n_o
);
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        cs_n_o = 1'b1;
        strobe_n_o = 1'b0;
    end
    // Half of a 400 ns serial period, well under the top serial rate.
    task automatic half();
        repeat (4) @(negedge clk_i);
    endtask
    task automatic frame_open();
        cs_n_o = 1'b0;
        half();
    endtask
    // Data changes while the clock is low, so it is steady at each rise.
    task automatic shift(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            sdata_o = w[i];
            half();
            sclk_o = 1'b1;
            half();
            sclk_o = 1'b0;
        end
    endtask
    task automatic frame_close();
        half();
        cs_n_o = 1'b1;
        sdata_o = ~sdata_o;
        half();
    endtask
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps

module tb;
    logic        ref_clk_i = 1'b0;
    logic        rstn_i    = 1'b0;
    logic        sclk, sdata, cs_n, strobe_n, upd, act;
    logic [15:0] code, bip;
    logic [4:0]  cnt;
    int          fail_count = 0;
    int          cmp_count  = 0;
    int          upd_count  = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    // Update pulses are counted on the falling edge, where the registered pulse is settled.
    always @(negedge ref_clk_i) begin
        if (upd === 1'b1) upd_count++;
    end
    sdi_host i_host (.clk_i(ref_clk_i), .sclk_o(sclk), .sdata_o(sdata), .cs_n_o(cs_n),
        .strobe_n_o(strobe_n));
    sdi_input_if i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .sdata_i(sdata),
        .cs_n_i(cs_n), .dac_update_strobe_n_i(strobe_n), .dac_code_o(code),
        .bipolar_signed_o(bip), .dac_updated_o(upd), .frame_active_o(act), .bit_count_o(cnt));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("Compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic word(input logic [31:0] w, input int n);
        i_host.frame_open();
        i_host.shift(w, n);
        i_host.frame_close();
        repeat (8) @(negedge ref_clk_i);
    endtask
    task automatic t_bytes();
        i_host.frame_open();
        i_host.shift(32'h0000_00C3, 8);
        check({11'h000, cnt}, 16'h0008);
        check({15'h0000, act}, 16'h0001);
        i_host.shift(32'h0000_007E, 8);
        i_host.frame_close();
        repeat (8) @(negedge ref_clk_i);
        check(code, 16'hC37E);
        check({11'h000, cnt}, 16'h0010);
    endtask
    task automatic t_strobe();
        i_host.strobe_n_o = 1'b1;
        word(32'h0000_8001, 16);
        check(code, 16'hC37E);
        check(upd_count[15:0], 16'h0004);
        i_host.strobe_n_o = 1'b0;
        repeat (8) @(negedge ref_clk_i);
        check(code, 16'h8001);
        check(bip, 16'h0001);
        check(upd_count[15:0], 16'h0005);
    endtask
    task automatic t_idle();
        i_host.shift(32'h0000_000F, 4);
        word(32'h0000_0000, 0);
        check(code, 16'h8001);
        check({11'h000, cnt}, 16'h0000);
        check(upd_count[15:0], 16'h0006);
    endtask
    task automatic t_reset();
        rstn_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        check(code, 16'h0000);
        rstn_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        check(code, 16'h0000);
        check(bip, sdi_pkg::BIPOLAR_ZERO);
        check({11'h000, cnt}, 16'h0000);
        word(32'h0000_5A5A, 16);
        check(code, 16'h5A5A);
        check(bip, 16'hDA5A);
        check(upd_count[15:0], 16'h0007);
    endtask
    initial begin
        repeat (5) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        check(code, 16'h0000);
        check(bip, sdi_pkg::BIPOLAR_ZERO);
        word(32'h0000_ABC0, 16);
        check(code, 16'hABC0);
        check(bip, 16'h2BC0);
        check({11'h000, cnt}, 16'h0010);
        check({15'h0000, act}, 16'h0000);
        check(upd_count[15:0], 16'h0001);
        word(32'h000F_1234, 20);
        check(code, 16'h1234);
        check({11'h000, cnt}, 16'h0010);
        word(32'h0000_005A, 8);
        check(code, 16'h345A);
        check({11'h000, cnt}, 16'h0008);
        t_bytes();
        t_strobe();
        t_idle();
        t_reset();
        stop_test();
    end
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
endmodule
